// ### adc_trigger_pkg.sv
package adc_trigger_pkg;

    // --------------------------------------------------------
    // register offsets
    // --------------------------------------------------------
    localparam logic [7:0] OFS_TRIG_CFG = 8'h01;
    localparam logic [7:0] OFS_CTRL2 = 8'h02;
    localparam logic [7:0] OFS_SEQ_START = 8'h05;
    localparam logic [7:0] OFS_STATUS = 8'h06;
    localparam logic [7:0] OFS_IRQ_EN = 8'h07;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
    localparam logic [7:0] OFS_DIEN_LO = 8'h0a;
    localparam logic [7:0] OFS_DIEN_HI = 8'h0b;

    // --------------------------------------------------------
    // trigger config fields
    // --------------------------------------------------------
    localparam int SRC_SEL_BIT = 7;
    localparam int RES_LSB = 5;
    localparam int DISCH_BIT = 4;
    localparam int CH_LSB = 0;
    localparam logic [1:0] RES_8BIT = 2'h0;
    localparam logic [1:0] RES_10BIT = 2'h1;
    localparam logic [3:0] CH_LAST = 4'hb;

    // --------------------------------------------------------
    // control two and sequence start fields
    // --------------------------------------------------------
    localparam int TRIG_EN_BIT = 2;
    localparam int TRIG_POL_BIT = 3;
    localparam int TRIG_LVL_BIT = 4;
    localparam int SCAN_BIT = 5;

    // --------------------------------------------------------
    // status layout, sticky events
    // --------------------------------------------------------
    localparam int EV_OVERRUN = 0;
    localparam int EV_SEQ_DONE = 1;
    localparam int EV_CFG_BAD = 2;
    localparam int BUSY_BIT = 4;
    localparam int ARMED_BIT = 5;
    localparam int NUM_EV = 3;

    // --------------------------------------------------------
    // reset values and timing
    // --------------------------------------------------------
    localparam logic [7:0] RST_TRIG_CFG = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_SEQ_START = 8'h00;
    localparam logic [1:0] DISCH_EXTRA_CYC = 2'h2;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN = 3'b100
    } seq_state_type;

endpackage : adc_trigger_pkg

// ### adc_trigger_control.sv
// How it works
// - config or control write aborts sequence
// - bit 7 picks dedicated or analog trigger
// - resolution code 00 8-bit, 01 10-bit
// - discharge bit adds two sample cycles
// - analog codes above 11 select channel 11
// - dedicated codes 0 to 3, rest reserved
// - trigger off: single or continuous scan
// - edge mode: one sequence per edge
// - level mode: convert while level active
// - trigger modes wait for first trigger
// - start write only arms when triggered
// - edge-mode edge during conversion sets overrun flag
// - level mode never sets overrun flag
// - active level restarts with no gap
// - per-pin digital buffer enable feeds port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module adc_trigger_control
    import adc_trigger_pkg::*;
#(
    parameter int NUM_CH = 12,
    parameter int NUM_DED = 4,
    parameter bit HAS_DEDICATED = 1'b1
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [NUM_CH-1:0] ANALOG_PIN_IN,
    input wire logic [NUM_DED-1:0] TRIGGER_IN,
    output logic [NUM_CH-1:0] PORT_DATA,
    input wire logic SEQ_DONE,
    output logic SEQ_START,
    output logic SEQ_ABORT,
    output logic [1:0] RESULT_RES,
    output logic DISCHARGE_EN,
    output logic [1:0] SAMPLE_EXTEND,
    output logic IRQ
);

    localparam int NPIN = NUM_CH + NUM_DED;

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ctrl2;
        logic [7:0] start;
        logic [15:0] dien;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] irq_en;
        seq_state_type st;
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] filt;
        logic trig_prev;
        logic seq_start;
        logic seq_abort;
        logic [7:0] rdata;
        logic [1:0] res;
        logic disch;
        logic [NUM_CH-1:0] port;
    } state_type;

    state_type q;
    state_type d;

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------

    // reserved resolution or source code
    function automatic logic cfg_reserved(
        input logic [7:0] cfg
    );
        logic bad;
        bad = cfg[RES_LSB+1];
        if (cfg[SRC_SEL_BIT] && HAS_DEDICATED) begin
            bad = bad | (cfg[CH_LSB+3:CH_LSB+2] != 2'h0);
        end
        return bad;
    endfunction : cfg_reserved

    // picks the selected trigger source level
    function automatic logic trig_pick(
        input logic [7:0] cfg,
        input logic [NPIN-1:0] pins
    );
        logic [3:0] ch;
        logic lvl;
        ch = cfg[CH_LSB+3:CH_LSB];
        lvl = 1'b0;
        if (cfg[SRC_SEL_BIT] && HAS_DEDICATED) begin
            lvl = pins[NUM_CH + int'(ch[1:0])];
        end else begin
            if (ch > CH_LAST) begin
                ch = CH_LAST;
            end
            lvl = pins[int'(ch)];
        end
        return lvl;
    endfunction : trig_pick

    // write strobe aimed at one register offset
    function automatic logic bus_hit(
        input logic strobe,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return strobe && (addr == ofs);
    endfunction : bus_hit

    // read mux over the register file, zero elsewhere
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input state_type s
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            OFS_TRIG_CFG: begin
                v = s.cfg;
            end
            OFS_CTRL2: begin
                v = s.ctrl2;
            end
            OFS_SEQ_START: begin
                v = s.start;
            end
            OFS_STATUS: begin
                v[NUM_EV-1:0] = s.status;
                v[BUSY_BIT] = (s.st == ST_RUN);
                v[ARMED_BIT] = (s.st == ST_ARMED);
            end
            OFS_IRQ_EN: begin
                v[NUM_EV-1:0] = s.irq_en;
            end
            OFS_DIEN_LO: begin
                v = s.dien[7:0];
            end
            OFS_DIEN_HI: begin
                v = s.dien[15:8];
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : read_mux

    // a pin change counts once stages two and three agree
    function automatic logic [NPIN-1:0] agree_filter(
        input logic [NPIN-1:0] mid,
        input logic [NPIN-1:0] last,
        input logic [NPIN-1:0] held
    );
        logic [NPIN-1:0] v;
        v = held;
        for (int i = 0; i < NPIN; i++) begin
            if (mid[i] == last[i]) begin
                v[i] = mid[i];
            end
        end
        return v;
    endfunction : agree_filter

    // sticky flags: a clear drops bits, a same-cycle event wins
    function automatic logic [NUM_EV-1:0] sticky_update(
        input logic [NUM_EV-1:0] old,
        input logic clr,
        input logic [NUM_EV-1:0] clr_bits,
        input logic [NUM_EV-1:0] ev
    );
        logic [NUM_EV-1:0] v;
        v = old;
        if (clr) begin
            v = old & ~clr_bits;
        end
        return v | ev;
    endfunction : sticky_update

    // --------------------------------------------------------
    // decoded controls
    // --------------------------------------------------------
    logic trig_en;
    logic trig_lvl;
    logic trig_pol;
    logic scan;
    logic wr_cfg;
    logic wr_ctrl2;
    logic wr_start;
    logic wr_clr;
    logic trig_raw;
    logic trig_act;
    logic trig_edge;
    logic bad_cfg;
    logic [NPIN-1:0] pins_en;

    // mode bits from the registers
    assign trig_en = q.ctrl2[TRIG_EN_BIT];
    assign trig_lvl = q.ctrl2[TRIG_LVL_BIT];
    assign trig_pol = q.ctrl2[TRIG_POL_BIT];
    assign scan = q.start[SCAN_BIT];
    assign bad_cfg = cfg_reserved(q.cfg);

    // write strobes per register
    assign wr_cfg = bus_hit(WR, ADDR, OFS_TRIG_CFG);
    assign wr_ctrl2 = bus_hit(WR, ADDR, OFS_CTRL2);
    assign wr_start = bus_hit(WR, ADDR, OFS_SEQ_START);
    assign wr_clr = bus_hit(WR, ADDR, OFS_IRQ_CLR);

    // analog pins pass only through enabled buffers
    assign pins_en = {q.filt[NPIN-1:NUM_CH],
        q.filt[NUM_CH-1:0] & q.dien[NUM_CH-1:0]};

    // polarity-corrected trigger and its edge
    assign trig_raw = trig_pick(q.cfg, pins_en);
    assign trig_act = trig_raw ~^ trig_pol;
    assign trig_edge = trig_act && !q.trig_prev;

    // --------------------------------------------------------
    // next state
    // --------------------------------------------------------
    always_comb begin
        logic [NUM_EV-1:0] ev;
        ev = '0;
        d = q;
        d.seq_start = 1'b0;
        d.seq_abort = 1'b0;
        d.rdata = 8'h00;

        // three-stage pin synchroniser with agree filter
        d.s1 = {TRIGGER_IN, ANALOG_PIN_IN};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = agree_filter(q.s2, q.s3, q.filt);
        d.trig_prev = trig_act;

        // port data through the per-pin buffers
        d.port = q.filt[NUM_CH-1:0] & q.dien[NUM_CH-1:0];

        // trigger config register
        if (wr_cfg) begin
            d.cfg = WDATA;
        end
        // control two register
        if (wr_ctrl2) begin
            d.ctrl2 = WDATA;
        end
        // sequence start register
        if (wr_start) begin
            d.start = WDATA;
        end
        // interrupt enable register
        if (bus_hit(WR, ADDR, OFS_IRQ_EN)) begin
            d.irq_en = WDATA[NUM_EV-1:0];
        end
        // pin buffer enables, low byte
        if (bus_hit(WR, ADDR, OFS_DIEN_LO)) begin
            d.dien[7:0] = WDATA;
        end
        // pin buffer enables, high byte
        if (bus_hit(WR, ADDR, OFS_DIEN_HI)) begin
            d.dien[15:8] = WDATA;
        end

        // registered result-width and discharge controls
        d.res = d.cfg[RES_LSB+1:RES_LSB];
        d.disch = d.cfg[DISCH_BIT];

        // sequencer
        case (q.st)
            // stopped, waits for a start write
            ST_IDLE: begin
                d.st = ST_IDLE;
            end
            // armed, waits for a trigger event
            ST_ARMED: begin
                if (bad_cfg) begin
                    d.st = ST_IDLE;
                    ev[EV_CFG_BAD] = 1'b1;
                end else if (!trig_en) begin
                    d.st = ST_IDLE;
                end else if (trig_lvl ? trig_act : trig_edge) begin
                    d.st = ST_RUN;
                    d.seq_start = 1'b1;
                end
            end
            // sequence running in the core
            ST_RUN: begin
                if (trig_en && !trig_lvl && trig_edge) begin
                    ev[EV_OVERRUN] = 1'b1;
                end
                if (SEQ_DONE) begin
                    ev[EV_SEQ_DONE] = 1'b1;
                    if (!trig_en) begin
                        d.st = scan ? ST_RUN : ST_IDLE;
                        d.seq_start = scan;
                    end else if (trig_lvl && trig_act) begin
                        d.seq_start = 1'b1;
                    end else begin
                        d.st = ST_ARMED;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // start write launches or arms a new sequence
        if (wr_start) begin
            d.seq_abort = (q.st == ST_RUN);
            if (bad_cfg) begin
                d.st = ST_IDLE;
                d.seq_start = 1'b0;
                ev[EV_CFG_BAD] = 1'b1;
            end else if (trig_en) begin
                d.st = ST_ARMED;
                d.seq_start = 1'b0;
            end else begin
                d.st = ST_RUN;
                d.seq_start = 1'b1;
            end
        end

        // config or control write kills the sequence
        if (wr_cfg || wr_ctrl2) begin
            d.st = ST_IDLE;
            d.seq_start = 1'b0;
            d.seq_abort = 1'b1;
        end

        // sticky flags: clear first, event wins
        d.status = sticky_update(q.status, wr_clr,
            WDATA[NUM_EV-1:0], ev);

        // read data, one cycle later
        if (RD) begin
            d.rdata = read_mux(ADDR, q);
        end
    end

    // --------------------------------------------------------
    // registers
    // --------------------------------------------------------
    // synchronous reset to idle values
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            q <= '0;
            q.cfg <= RST_TRIG_CFG;
            q.ctrl2 <= RST_CTRL2;
            q.start <= RST_SEQ_START;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    // bus read data and buffered port levels
    assign RDATA = q.rdata;
    assign PORT_DATA = q.port;

    // sequence pulses and sample settings
    assign SEQ_START = q.seq_start;
    assign SEQ_ABORT = q.seq_abort;
    assign RESULT_RES = q.res;
    assign DISCHARGE_EN = q.disch;
    assign SAMPLE_EXTEND = q.disch ? DISCH_EXTRA_CYC : 2'h0;

    // level interrupt from enabled sticky flags
    assign IRQ = |(q.status & q.irq_en);

endmodule : adc_trigger_control

// ### adc_core_model.sv
`timescale 1ns/10ps

module adc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] lat,
    output logic done
);
    logic [7:0] cnt_q;
    // ------------------------------------
    // conversion core: done lat cycles on
    // ------------------------------------
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (start) begin
            cnt_q <= lat;
        end else if (abort) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            done <= (cnt_q == 8'h01);
        end
    end
endmodule : adc_core_model

// ### adc_trigger_control_monitor.sv
`timescale 1ns/10ps

module adc_trigger_control_monitor
    import adc_trigger_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SEQ_START,
    input wire logic SEQ_ABORT,
    input wire logic [1:0] RESULT_RES,
    input wire logic DISCHARGE_EN,
    input wire logic [1:0] SAMPLE_EXTEND,
    input wire logic IRQ
);
    // ------------------------------------
    // shadow of enable and bad config
    // ------------------------------------
    logic en_q;
    logic bad_q;
    logic wcfg;
    logic wst;
    assign wcfg = WR && (ADDR == OFS_TRIG_CFG);
    assign wst = WR && (ADDR == OFS_SEQ_START);
    // track writes
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            en_q <= 1'b0;
            bad_q <= 1'b0;
        end else if (WR && ADDR == OFS_CTRL2) begin
            en_q <= WDATA[TRIG_EN_BIT];
        end else if (wcfg) begin
            bad_q <= WDATA[6] | (WDATA[SRC_SEL_BIT] & (|WDATA[3:2]));
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // ------------------------------------
    // properties
    // ------------------------------------
    AST_ABORT_ON_WRITE: assert property (
        WR && (ADDR == OFS_TRIG_CFG || ADDR == OFS_CTRL2) |=> SEQ_ABORT)
        else $error("no abort after config write");
    AST_ABORT_CAUSE: assert property (
        SEQ_ABORT |-> $past(WR)) else $error("abort without write");
    AST_RES: assert property (
        wcfg && !WDATA[6] |=> RESULT_RES == $past(WDATA[6:5]))
        else $error("resolution not decoded");
    AST_DISCH: assert property (
        wcfg |=> DISCHARGE_EN == $past(WDATA[DISCH_BIT]))
        else $error("discharge not decoded");
    AST_EXTEND: assert property (
        SAMPLE_EXTEND == (DISCHARGE_EN ? DISCH_EXTRA_CYC : 2'h0))
        else $error("sample extension wrong");
    AST_SOFT_START: assert property (
        wst && !en_q && !bad_q |=> ##[0:2] SEQ_START)
        else $error("software start missing");
    AST_ARM_ONLY: assert property (
        wst && en_q |=> !SEQ_START) else $error("start without trigger");
    AST_BAD_START: assert property (
        wst && bad_q |=> !SEQ_START [*3]) else $error("bad config ran");
    AST_READ_IDLE: assert property (
        !RD |=> RDATA == 8'h00) else $error("read data not idle");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        RST |=> !SEQ_START && !SEQ_ABORT && !IRQ)
        else $error("outputs active in reset");
    cover property (SEQ_ABORT);
    cover property (IRQ ##[1:5] !IRQ);
    cover property (SEQ_START ##1 !SEQ_START ##[1:40] SEQ_START);
endmodule : adc_trigger_control_monitor

bind adc_trigger_control adc_trigger_control_monitor mon (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SEQ_START(SEQ_START),
    .SEQ_ABORT(SEQ_ABORT), .RESULT_RES(RESULT_RES),
    .DISCHARGE_EN(DISCHARGE_EN), .SAMPLE_EXTEND(SAMPLE_EXTEND),
    .IRQ(IRQ));

// ### tb_adc_trigger_control.sv
`timescale 1ns/10ps

module tb_adc_trigger_control;
    import adc_trigger_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [1:0] res;
        logic dis;
    } row_type;
    logic CLOCK, RST, WR, RD, SEQ_DONE, SEQ_START, SEQ_ABORT;
    logic DISCHARGE_EN, IRQ;
    logic [7:0] ADDR, WDATA, RDATA, lat, v;
    logic [11:0] ANALOG_PIN_IN, PORT_DATA;
    logic [3:0] TRIGGER_IN;
    logic [1:0] RESULT_RES, SAMPLE_EXTEND;
    int failures = 0, cmp_count = 0, nstart = 0, i;
    row_type rows [4] = '{'{8'h00, 2'h0, 1'b0}, '{8'h30, 2'h1, 1'b1},
        '{8'h2b, 2'h1, 1'b0}, '{8'h1c, 2'h0, 1'b1}};
    logic [7:0] bad_cfg [2] = '{8'h60, 8'h84};

    adc_trigger_control uut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .ANALOG_PIN_IN(ANALOG_PIN_IN), .TRIGGER_IN(TRIGGER_IN),
        .PORT_DATA(PORT_DATA), .SEQ_DONE(SEQ_DONE),
        .SEQ_START(SEQ_START), .SEQ_ABORT(SEQ_ABORT),
        .RESULT_RES(RESULT_RES), .DISCHARGE_EN(DISCHARGE_EN),
        .SAMPLE_EXTEND(SAMPLE_EXTEND), .IRQ(IRQ));
    adc_core_model core (.clk(CLOCK), .rst(RST), .start(SEQ_START),
        .abort(SEQ_ABORT), .lat(lat), .done(SEQ_DONE));

    // ------------------------------------
    // clock, start counter, bus tasks
    // ------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // count sequence starts
    always @(posedge CLOCK) if (SEQ_START === 1'b1) nstart <= nstart + 1;

    task idle(input int n);
        repeat (n) @(posedge CLOCK);
    endtask : idle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task chk(input logic [11:0] s, input logic [11:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task chkrd(input logic [7:0] a, input logic [7:0] e);
        rd(a, v);
        chk(12'(v), 12'(e));
    endtask : chkrd
    task end_of_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task wait_cnt(input int n);
        int k;
        for (k = 0; k < 80 && nstart < n; k++) @(posedge CLOCK);
        if (nstart < n) begin
            failures++;
            $display("[FAIL] %0t no sequence start", $time);
            end_of_test;
        end
    endtask : wait_cnt
    task wait_done;
        int k;
        #1;
        for (k = 0; k < 60 && SEQ_DONE !== 1'b1; k++) begin
            @(posedge CLOCK);
            #1;
        end
        if (SEQ_DONE !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t no sequence done", $time);
            end_of_test;
        end
        @(posedge CLOCK);
        #1;
    endtask : wait_done

    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 8'h00; WDATA = 8'h00;
        ANALOG_PIN_IN = 12'h000; TRIGGER_IN = 4'h0; lat = 8'h04;
        idle(16);
        RST <= 1'b0;
        chkrd(OFS_TRIG_CFG, 8'h00);
        chkrd(OFS_CTRL2, 8'h00);
        chkrd(8'h0f, 8'h00);
        chk(12'(IRQ), 12'h0);
        // decode table
        foreach (rows[k]) begin
            wr(OFS_TRIG_CFG, rows[k].cfg);
            @(posedge CLOCK);
            #1;
            chk(12'(RESULT_RES), 12'(rows[k].res));
            chk(12'(DISCHARGE_EN), 12'(rows[k].dis));
            chk(12'(SAMPLE_EXTEND), rows[k].dis ? 12'h2 : 12'h0);
            chkrd(OFS_TRIG_CFG, rows[k].cfg);
        end
        // software single, continuous, then abort
        wr(OFS_TRIG_CFG, 8'h00);
        i = nstart;
        wr(OFS_SEQ_START, 8'h00);
        wait_cnt(i + 1);
        idle(20);
        chk(12'(nstart - i), 12'h1);
        i = nstart;
        wr(OFS_SEQ_START, 8'h20);
        idle(40);
        chk(12'(nstart - i > 2), 12'h1);
        wr(OFS_CTRL2, 8'h00);
        idle(3);
        i = nstart;
        idle(20);
        chk(12'(nstart - i), 12'h0);
        // edge mode, rising, analog pin 0
        wr(OFS_DIEN_LO, 8'h01);
        wr(OFS_CTRL2, 8'h0c);
        i = nstart;
        wr(OFS_SEQ_START, 8'h00);
        idle(10);
        chk(12'(nstart - i), 12'h0);
        lat <= 8'h30;
        ANALOG_PIN_IN <= 12'h003;
        wait_cnt(i + 1);
        chk(PORT_DATA, 12'h001);
        ANALOG_PIN_IN <= 12'h000;
        idle(6);
        ANALOG_PIN_IN <= 12'h001;
        idle(8);
        chk(12'(nstart - i), 12'h1);
        rd(OFS_STATUS, v);
        chk(12'(v[EV_OVERRUN]), 12'h1);
        chk(12'(IRQ), 12'h0);
        wr(OFS_IRQ_EN, 8'h01);
        idle(2);
        chk(12'(IRQ), 12'h1);
        wr(OFS_IRQ_CLR, 8'h01);
        idle(2);
        chk(12'(IRQ), 12'h0);
        // level mode, high, dedicated input 1
        lat <= 8'h10;
        wr(OFS_TRIG_CFG, 8'h81);
        wr(OFS_CTRL2, 8'h1c);
        wr(OFS_SEQ_START, 8'h00);
        wr(OFS_IRQ_CLR, 8'h07);
        i = nstart;
        TRIGGER_IN <= 4'h2;
        wait_cnt(i + 1);
        TRIGGER_IN <= 4'h0;
        idle(3);
        TRIGGER_IN <= 4'h2;
        wait_done;
        chk(12'(SEQ_START), 12'h1);
        rd(OFS_STATUS, v);
        chk(12'(v[EV_OVERRUN]), 12'h0);
        TRIGGER_IN <= 4'h0;
        idle(40);
        i = nstart;
        idle(30);
        chk(12'(nstart - i), 12'h0);
        // reserved configurations
        wr(OFS_CTRL2, 8'h00);
        foreach (bad_cfg[k]) begin
            wr(OFS_TRIG_CFG, bad_cfg[k]);
            wr(OFS_IRQ_CLR, 8'h04);
            i = nstart;
            wr(OFS_SEQ_START, 8'h00);
            idle(8);
            chk(12'(nstart - i), 12'h0);
            rd(OFS_STATUS, v);
            chk(12'(v[EV_CFG_BAD]), 12'h1);
        end
        // reset while idle with the bad-config flag set clears flags, enables and interrupt
        wr(OFS_IRQ_EN, 8'h07);
        RST <= 1'b1;
        idle(2);
        RST <= 1'b0;
        chkrd(OFS_STATUS, 8'h00);
        chkrd(OFS_IRQ_EN, 8'h00);
        chk(12'(IRQ), 12'h0);
        end_of_test;
    end
endmodule : tb_adc_trigger_control
